//--- logic/sps_pkg.sv
// constants and field layout for the serial pll synthesizer core
// How it works
// - each rising shift-clock edge moves one serial data bit into the shift register
// - last bit picks target: high to 14-bit reference latch, low to 18-bit main latch
// - while load strobe is high the shifted word is copied into the chosen latch
// - main word bits 1-7 give swallow ratio, bits 8-18 programmable ratio
// - swallow factor is plain binary, bit one lsb, any value 0 to 127
// - on-chip pump drives high if reference faster, floats if equal, low if slower
// - external pumps: faster both low; equal ref low vco floats; slower ref high
// - lock output low while both divided signals are coherent, high otherwise
// - modulus output high picks lower prescaler modulus, low picks higher one
// - power select input high means run, low means power-down
// - loop-control output goes high on the first fr in operation mode, low in power-down
// - monitor output shows the reference divider output fed to the comparator
// - output frequency follows (n times modulus plus a) times osc over r
// - power-down stops and clears dividers; main starts first, reference on first fp
package sps_pkg;
    localparam int SPS_SWALLOW_W = 7;
    localparam int SPS_PROG_W = 11;
    localparam int SPS_REF_W = 14;
    localparam int SPS_MAIN_W = SPS_SWALLOW_W + SPS_PROG_W;
    localparam int SPS_SHIFT_W = SPS_MAIN_W + 1;
    localparam int SPS_CTL_POS = 0;
    localparam int SPS_DATA_LSB = 1;
    localparam logic [SPS_MAIN_W-1:0] SPS_MAIN_RST = 18'h00280;
    localparam logic [SPS_REF_W-1:0] SPS_REF_RST = 14'h0008;
    // wishbone map, byte addresses of 32-bit words
    localparam int SPS_ADR_W = 4;
    localparam logic [SPS_ADR_W-1:0] SPS_ADR_CTRL = 4'h0;
    localparam logic [SPS_ADR_W-1:0] SPS_ADR_STATUS = 4'h4;
    localparam logic [SPS_ADR_W-1:0] SPS_ADR_MAIN = 4'h8;
    localparam logic [SPS_ADR_W-1:0] SPS_ADR_REF = 4'hC;
    localparam int SPS_CTRL_PD_POS = 0;
    localparam int SPS_ST_LOCK_POS = 0;
    localparam int SPS_ST_LOOP_POS = 1;
    localparam int SPS_ST_UP_POS = 2;
    localparam int SPS_ST_DN_POS = 3;
    localparam int SPS_ST_MOD_POS = 4;
    localparam int SPS_ST_ARMED_POS = 5;
endpackage : sps_pkg

//--- logic/sps_div.sv
// programmable divide-by-ratio counter on input ticks
`timescale 1ns/1ps
module sps_div #(
    parameter int W = 14
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic tick_i,
    input wire logic [W-1:0] ratio_i,
    output logic pulse_o
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] reload;
    logic at_end;

    // ratio is sampled only at reload, so a new load never cuts a cycle short
    assign reload = ratio_i - W'(1);
    assign at_end = (cnt_reg == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            cnt_reg <= reload;
            pulse_o <= 1'b0;
        end else begin
            pulse_o <= tick_i && at_end;
            if (tick_i) begin
                cnt_reg <= at_end ? reload : cnt_reg - W'(1);
            end
        end
    end
endmodule : sps_div

//--- logic/sps_core.sv
// serial pll synthesizer digital core with wishbone status port
`timescale 1ns/1ps
module sps_core
    import sps_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [SPS_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial programming port
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic load_strobe_i,
    // pins
    input wire logic osc_amp_in_i,
    input wire logic prescaler_in_i,
    input wire logic power_select_in_i,
    output logic loop_ctrl_out_o,
    output logic lock_detect_out_o,
    output logic mod_ctrl_o,
    output logic ref_div_monitor_o,
    output logic main_div_output_o,
    output logic pump_out_o,
    output logic pump_oe_n_o,
    output logic ext_ref_pump_o,
    output logic ext_vco_pump_o,
    output logic ext_vco_pump_oe_n_o
);
    // serial shift register, link clock domain
    logic [SPS_SHIFT_W-1:0] shift_reg;

    always_ff @(posedge ser_clk_i) begin
        shift_reg <= {shift_reg[SPS_SHIFT_W-2:0], ser_data_i};
    end

    // pin synchronisers
    logic le_s1_reg;
    logic le_s2_reg;
    logic ps_s1_reg;
    logic ps_s2_reg;
    logic osc_s1_reg;
    logic osc_s2_reg;
    logic osc_s3_reg;
    logic fin_s1_reg;
    logic fin_s2_reg;
    logic fin_s3_reg;

    always_ff @(posedge clk_i) begin
        le_s1_reg <= load_strobe_i;
        le_s2_reg <= le_s1_reg;
        ps_s1_reg <= power_select_in_i;
        ps_s2_reg <= ps_s1_reg;
        osc_s1_reg <= osc_amp_in_i;
        osc_s2_reg <= osc_s1_reg;
        osc_s3_reg <= osc_s2_reg;
        fin_s1_reg <= prescaler_in_i;
        fin_s2_reg <= fin_s1_reg;
        fin_s3_reg <= fin_s2_reg;
    end

    wire osc_tick = osc_s2_reg && !osc_s3_reg;
    wire fin_tick = fin_s2_reg && !fin_s3_reg;

    // delayed tick lines up with the registered fp pulse, so the swallow
    // span covers whole prescaler periods, not one clock short
    logic fin_tick_d_reg;

    always_ff @(posedge clk_i) begin
        fin_tick_d_reg <= fin_tick;
    end

    // software control
    logic pd_force_reg;
    logic [31:0] dat_next;
    logic ack_reg;

    wire run = ps_s2_reg && !pd_force_reg;
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wb_wr = wb_req && wb_we_i;
    wire ctrl_wr = wb_wr && (wb_adr_i == SPS_ADR_CTRL) && wb_sel_i[0];

    // ratio latches; word is quiet while the strobe is high because the host
    // holds the shift clock still then, so no per-bit synchroniser is needed
    logic [SPS_MAIN_W-1:0] main_ratio_reg;
    logic [SPS_REF_W-1:0] ref_ratio_reg;

    wire to_ref = shift_reg[SPS_CTL_POS];
    wire load_ref = le_s2_reg && to_ref;
    wire load_main = le_s2_reg && !to_ref;
    wire [SPS_REF_W-1:0] ref_word = shift_reg[SPS_DATA_LSB +: SPS_REF_W];
    wire [SPS_MAIN_W-1:0] main_word = shift_reg[SPS_DATA_LSB +: SPS_MAIN_W];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_ratio_reg <= SPS_MAIN_RST;
            ref_ratio_reg <= SPS_REF_RST;
        end else begin
            if (load_main) begin
                main_ratio_reg <= main_word;
            end
            if (load_ref) begin
                ref_ratio_reg <= ref_word;
            end
        end
    end

    wire [SPS_SWALLOW_W-1:0] swallow_ratio = main_ratio_reg[SPS_SWALLOW_W-1:0];
    wire [SPS_PROG_W-1:0] prog_ratio = main_ratio_reg[SPS_MAIN_W-1:SPS_SWALLOW_W];

    // main divider: programmable counter plus swallow counter
    logic fp_pulse;
    logic fr_pulse;
    logic ref_armed_reg;
    logic [SPS_SWALLOW_W-1:0] swallow_cnt_reg;
    logic mod_reg;

    sps_div #(
        .W(SPS_PROG_W)
    ) u_prog_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run),
        .tick_i(fin_tick),
        .ratio_i(prog_ratio),
        .pulse_o(fp_pulse)
    );

    // swallow count saturates at the ratio; cleared each main cycle
    wire swallowing = swallow_cnt_reg < swallow_ratio;
    wire [SPS_SWALLOW_W-1:0] swallow_next =
        fp_pulse ? '0 :
        (fin_tick_d_reg && swallowing) ? swallow_cnt_reg + SPS_SWALLOW_W'(1) : swallow_cnt_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            swallow_cnt_reg <= '0;
            mod_reg <= 1'b0;
            ref_armed_reg <= 1'b0;
        end else begin
            swallow_cnt_reg <= swallow_next;
            mod_reg <= !(swallow_next < swallow_ratio);
            ref_armed_reg <= ref_armed_reg || fp_pulse;
        end
    end

    // reference divider starts only once the main divider has produced fp
    sps_div #(
        .W(SPS_REF_W)
    ) u_ref_div (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run && ref_armed_reg),
        .tick_i(osc_tick),
        .ratio_i(ref_ratio_reg),
        .pulse_o(fr_pulse)
    );

    // phase-frequency detector: fr first means reference faster
    logic up_reg;
    logic dn_reg;
    logic loop_reg;
    logic fr_mon_reg;
    logic fp_mon_reg;

    wire up_set = up_reg || fr_pulse;
    wire dn_set = dn_reg || fp_pulse;
    wire both = up_set && dn_set;
    wire up_next = up_set && !both;
    wire dn_next = dn_set && !both;

    always_ff @(posedge clk_i) begin
        if (rst_i || !run) begin
            up_reg <= 1'b0;
            dn_reg <= 1'b0;
            loop_reg <= 1'b0;
        end else begin
            up_reg <= up_next;
            dn_reg <= dn_next;
            loop_reg <= loop_reg || fr_pulse;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pump_out_o <= 1'b0;
            pump_oe_n_o <= 1'b1;
            ext_ref_pump_o <= 1'b0;
            ext_vco_pump_o <= 1'b0;
            ext_vco_pump_oe_n_o <= 1'b1;
            lock_detect_out_o <= 1'b0;
            fr_mon_reg <= 1'b0;
            fp_mon_reg <= 1'b0;
        end else begin
            pump_out_o <= up_next;
            pump_oe_n_o <= !(up_next || dn_next);
            ext_ref_pump_o <= dn_next;
            ext_vco_pump_o <= 1'b0;
            ext_vco_pump_oe_n_o <= !up_next;
            lock_detect_out_o <= up_next || dn_next;
            fr_mon_reg <= fr_pulse;
            fp_mon_reg <= fp_pulse;
        end
    end

    assign loop_ctrl_out_o = loop_reg;
    assign mod_ctrl_o = mod_reg;
    assign ref_div_monitor_o = fr_mon_reg;
    assign main_div_output_o = fp_mon_reg;

    // register bus: one-cycle answer, unmapped reads give zero
    wire [31:0] status_word = 32'(
        {ref_armed_reg, mod_reg, dn_reg, up_reg, loop_reg, lock_detect_out_o});

    always_comb begin
        unique case (wb_adr_i)
            SPS_ADR_CTRL: dat_next = 32'(pd_force_reg);
            SPS_ADR_STATUS: dat_next = status_word;
            SPS_ADR_MAIN: dat_next = 32'(main_ratio_reg);
            SPS_ADR_REF: dat_next = 32'(ref_ratio_reg);
            default: dat_next = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pd_force_reg <= 1'b0;
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req;
            wb_dat_o <= wb_req ? dat_next : 32'h0000_0000;
            if (ctrl_wr) begin
                pd_force_reg <= wb_dat_i[SPS_CTRL_PD_POS];
            end
        end
    end

    assign wb_ack_o = ack_reg;
endmodule : sps_core

//--- verif/sps_core_chk.sv
// port assertions for the synthesizer core
`timescale 1ns/1ps
module sps_core_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic power_select_in_i,
    input wire logic loop_ctrl_out_o,
    input wire logic lock_detect_out_o,
    input wire logic pump_out_o,
    input wire logic pump_oe_n_o,
    input wire logic ext_ref_pump_o,
    input wire logic ext_vco_pump_o,
    input wire logic ext_vco_pump_oe_n_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_up; (!pump_oe_n_o && pump_out_o) |-> !ext_ref_pump_o && !ext_vco_pump_oe_n_o;
    endproperty
    a_up: assert property (p_up) else $error("ext pumps when up");
    property p_dn; (!pump_oe_n_o && !pump_out_o) |-> ext_ref_pump_o && ext_vco_pump_oe_n_o;
    endproperty
    a_dn: assert property (p_dn) else $error("ext pumps when down");
    property p_eq; pump_oe_n_o |-> !ext_ref_pump_o && ext_vco_pump_oe_n_o; endproperty
    a_eq: assert property (p_eq) else $error("ext pumps when equal");
    property p_lock; lock_detect_out_o == !pump_oe_n_o; endproperty
    a_lock: assert property (p_lock) else $error("lock level");
    property p_vco0; !ext_vco_pump_o; endproperty
    a_vco0: assert property (p_vco0) else $error("vco pump high");
    // ps is async, so allow the synchroniser to settle
    property p_loop; !power_select_in_i [*6] |-> !loop_ctrl_out_o; endproperty
    a_loop: assert property (p_loop) else $error("loop in power-down");
endmodule : sps_core_chk

bind sps_core sps_core_chk u_sps_core_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .power_select_in_i, .loop_ctrl_out_o, .lock_detect_out_o, .pump_out_o, .pump_oe_n_o,
    .ext_ref_pump_o, .ext_vco_pump_o, .ext_vco_pump_oe_n_o);

//--- verif/sps_host.sv
// serial host, oscillator and prescaler stand-in
`timescale 1ns/1ps
module sps_host (
    input wire logic [7:0] pre_half_i,
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic load_strobe_o,
    output logic osc_o,
    output logic pre_o
);
    initial begin
        {ser_clk_o, ser_data_o, load_strobe_o, osc_o, pre_o} = 5'h00;
        #3;
        fork
            forever #50 osc_o = ~osc_o;
            forever #(pre_half_i) pre_o = ~pre_o;
        join
    end
    // msb first; clock idles low, data flips so stale bits never look valid
    task automatic send(input logic [18:0] w, input logic le);
        #3;
        for (int i = 18; i >= 0; i--) begin
            ser_data_o = w[i];
            #80 ser_clk_o = 1'b1;
            #80 ser_clk_o = 1'b0;
        end
        ser_data_o = ~ser_data_o;
        #40 load_strobe_o = le;
        #80 load_strobe_o = 1'b0;
        #40;
    endtask : send
endmodule : sps_host

//--- verif/sps_core_bench.sv
// self-checking bench for the synthesizer core
`timescale 1ns/1ps
module sps_core_bench
    import sps_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic power_select_in_i = 1'b1, ser_clk_i, ser_data_i, load_strobe_i;
    logic osc_amp_in_i, prescaler_in_i, wb_ack_o, loop_ctrl_out_o, lock_detect_out_o;
    logic mod_ctrl_o, ref_div_monitor_o, main_div_output_o, pump_out_o, pump_oe_n_o;
    logic ext_ref_pump_o, ext_vco_pump_o, ext_vco_pump_oe_n_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic [7:0] pre_half = 8'h64;
    int errors = 0, cmp_count = 0, cyc_n = 0, per, low;
    sps_core u_sps_core (.*);
    sps_host u_sps_host (.pre_half_i(pre_half), .ser_clk_o(ser_clk_i), .ser_data_o(ser_data_i),
        .load_strobe_o(load_strobe_i), .osc_o(osc_amp_in_i), .pre_o(prescaler_in_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 60000) begin
            errors++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict;
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : print_verdict
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask : rd
    // cycles between two pulses, and cycles of higher modulus inside them
    task automatic meas(input logic sel);
        int k;
        {per, low, k} = '0;
        while (k < 2) begin
            @(posedge clk_i);
            if ((sel ? ref_div_monitor_o : main_div_output_o) === 1'b1) k++;
            if (k == 1) begin
                per++;
                if (mod_ctrl_o === 1'b0) low++;
            end
        end
    endtask : meas
    task automatic see(input logic v);
        int t;
        t = 0;
        while (!(pump_oe_n_o === 1'b0 && pump_out_o === v) && t < 3000) begin
            @(posedge clk_i);
            t++;
        end
        chk(32'(t < 3000), 32'h1);
        chk(lock_detect_out_o, 32'h1);
    endtask : see
    task automatic t_load;
        rd(SPS_ADR_MAIN, 32'(SPS_MAIN_RST));
        rd(4'h2, 32'h0);
        u_sps_host.send({4'h0, 14'h0009, 1'b1}, 1'b0);
        rd(SPS_ADR_REF, 32'(SPS_REF_RST));
        u_sps_host.send({11'h006, 7'h03, 1'b0}, 1'b1);
        rd(SPS_ADR_MAIN, {14'h0, 11'h006, 7'h03});
        rd(SPS_ADR_REF, 32'(SPS_REF_RST));
        u_sps_host.send({4'h0, 14'h0009, 1'b1}, 1'b1);
        rd(SPS_ADR_REF, 32'h9);
        rd(SPS_ADR_MAIN, {14'h0, 11'h006, 7'h03});
    endtask : t_load
    task automatic t_div;
        repeat (2) meas(1'b0);
        chk(per, 32'd120);
        chk(low, 32'd60);
        meas(1'b1);
        chk(per, 32'd90);
    endtask : t_div
    task automatic t_pump;
        see(1'b1);
        pre_half <= 8'h32;
        see(1'b0);
        pre_half <= 8'h64;
    endtask : t_pump
    task automatic t_pd;
        int n;
        n = 0;
        wb(1'b1, SPS_ADR_CTRL, 32'h1);
        // a pulse launched on the taking edge may still be in the monitor flop
        repeat (2) @(posedge clk_i);
        repeat (300) begin
            @(posedge clk_i);
            if (ref_div_monitor_o === 1'b1) n++;
        end
        chk(n, 32'h0);
        rd(SPS_ADR_STATUS, 32'h0);
        wb(1'b1, SPS_ADR_CTRL, 32'h0);
        repeat (400) @(posedge clk_i);
        wb(1'b0, SPS_ADR_STATUS, 32'h0);
        chk(q[SPS_ST_LOOP_POS], 32'h1);
        power_select_in_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        wb(1'b0, SPS_ADR_STATUS, 32'h0);
        chk(q[SPS_ST_LOOP_POS], 32'h0);
        power_select_in_i <= 1'b1;
    endtask : t_pd
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_load();
        t_div();
        t_pump();
        t_pd();
        print_verdict();
    end
endmodule : sps_core_bench
